// *** src/uif_pkg.sv ***
// Constants of the USB interrupt funnel: offsets, bit positions, resets.
// Assumes a byte-wide register port and a 25 MHz module clock.
//
// Summary of operation
// - All USB sources merge into one request for peripheral flag bit 5.
// - Request is the OR of status flags each gated by its enable.
// - Any enabled error flag sets the error summary status bit.
// - Status enables gate only the request; status flags always set.
// - Error enables gate only the summary; error flags always set.
// - Error summary comes only from enabled errors, ignores writes.
// - Engine-set flags stay set until software writes 0 to them.
// - Software writing 1 sets status flags, except the summary.
// - Frame start flag, bit 6, sets on each start-of-frame token.
// - Stall flag, bit 5, sets when a STALL handshake is sent.
// - Idle flag, bit 4, sets after 3 ms of continuous bus Idle.
// - Transaction flag, bit 3; clearing it advances status FIFO.
// - Activity flag, bit 2, sets on D+ or D- activity.
// - Bus reset sets flag bit 0 and loads 00h into device address.
// - Error flags set at once on detection, not deferred.
// - Bit stuff error flag at error bit 7.
// - Turnaround time-out flag at bit 4: over 16 Idle bit times.
// - Data field size error flag at error bit 3.
// - CRC16 failure flag at error bit 2.
// - Bad CRC5 token rejected; CRC5 error flag at bit 1.
// - PID check failure flag at error bit 0.
package uif_pkg;
  // Register offsets on the byte port
  localparam logic [2:0] OFS_STATUS_FLAGS   = 3'h0;
  localparam logic [2:0] OFS_STATUS_ENABLES = 3'h1;
  localparam logic [2:0] OFS_ERROR_FLAGS    = 3'h2;
  localparam logic [2:0] OFS_ERROR_ENABLES  = 3'h3;
  localparam logic [2:0] OFS_DEVICE_ADDRESS = 3'h4;
  localparam logic [2:0] OFS_PERIPH_FLAGS   = 3'h5;

  // Status flag positions
  localparam int BIT_FRAME_START = 6;
  localparam int BIT_STALL_SENT  = 5;
  localparam int BIT_BUS_IDLE    = 4;
  localparam int BIT_TRANS_DONE  = 3;
  localparam int BIT_BUS_ACTIV   = 2;
  localparam int BIT_ERR_SUMMARY = 1;
  localparam int BIT_BUS_RESET   = 0;

  // Error flag positions
  localparam int BIT_STUFF_ERR   = 7;
  localparam int BIT_TURN_TMO    = 4;
  localparam int BIT_FIELD_SIZE  = 3;
  localparam int BIT_DATA_CRC    = 2;
  localparam int BIT_TOKEN_CRC   = 1;
  localparam int BIT_PID_CHECK   = 0;

  // Peripheral flag register position of the combined request
  localparam int BIT_USB_REQUEST = 5;

  // Implemented bits and reset values
  localparam logic [7:0] STATUS_MASK   = 8'h7f;
  localparam logic [7:0] STATUS_SW_SET = 8'h7d;
  localparam logic [7:0] ERROR_MASK    = 8'h9f;
  localparam logic [7:0] RESET_FLAGS   = 8'h00;
  localparam logic [6:0] RESET_ADDRESS = 7'h00;

  // Idle detect timing
  localparam int CLOCK_HZ       = 25_000_000;
  localparam int IDLE_TIME_US   = 3000;
  localparam int IDLE_CYCLES    = (CLOCK_HZ / 1_000_000) * IDLE_TIME_US;
endpackage

// *** src/uif_flag_bit.sv ***
// One sticky interrupt flag: hardware set, software set and clear.
// Assumes writes are single-cycle strobes on the module clock.
`timescale 1ns/100ps
module uif_flag_bit (
  // Clock, reset, clock enable
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic enable_i,
  // Set and clear requests
  input  wire logic hw_set_i,
  input  wire logic sw_write_i,
  input  wire logic sw_value_i,
  input  wire logic sw_set_ok_i,
  // Flag
  output logic      flag_o
);
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_o <= 1'b0;
    end else if (enable_i) begin
      if (hw_set_i) begin
        flag_o <= 1'b1;
      end else if (sw_write_i && !sw_value_i) begin
        flag_o <= 1'b0;
      end else if (sw_write_i && sw_value_i && sw_set_ok_i) begin
        flag_o <= 1'b1;
      end
    end
  end
endmodule

// *** src/uif_funnel.sv ***
// USB interrupt funnel: two levels of sticky flags, enables, one request.
// Assumes engine event inputs are single-cycle pulses on clock_i, except
// bus_idle_i, a level that is high while the bus sits in Idle.
`timescale 1ns/100ps
module uif_funnel #(
  parameter int IDLE_CYCLES = uif_pkg::IDLE_CYCLES
) (
  // Clock, reset, clock enable
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       clock_en_i,
  // Register port
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  // Serial interface engine events
  input  wire logic       frame_start_i,
  input  wire logic       stall_sent_i,
  input  wire logic       bus_idle_i,
  input  wire logic       transaction_done_i,
  input  wire logic       bus_activity_i,
  input  wire logic       bus_reset_i,
  input  wire logic       stuffing_error_i,
  input  wire logic       turnaround_timeout_i,
  input  wire logic       field_size_error_i,
  input  wire logic       data_crc_error_i,
  input  wire logic       token_crc_error_i,
  input  wire logic       pid_check_error_i,
  // Outputs toward the processor and the engine
  output logic            combined_usb_request_flag_o,
  output logic      [7:0] peripheral_flag_reg_two_o,
  output logic      [6:0] device_address_reg_o,
  output logic            token_crc_reject_o,
  output logic            status_fifo_advance_o
);
  localparam int CW = $clog2(IDLE_CYCLES + 1);

  if (IDLE_CYCLES < 1) begin : g_bad_idle
    $error("IDLE_CYCLES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register write decode
  logic       wr_status;
  logic       wr_status_en;
  logic       wr_error;
  logic       wr_error_en;
  logic       wr_address;
  logic [7:0] usb_status_flags;
  logic [7:0] usb_status_enables;
  logic [7:0] usb_error_flags;
  logic [7:0] usb_error_enables;
  logic [7:0] status_events;
  logic [7:0] error_events;
  logic       idle_event;
  logic       error_summary_flag;

  assign wr_status    = reg_write_i && reg_addr_i == uif_pkg::OFS_STATUS_FLAGS;
  assign wr_status_en = reg_write_i &&
                        reg_addr_i == uif_pkg::OFS_STATUS_ENABLES;
  assign wr_error     = reg_write_i && reg_addr_i == uif_pkg::OFS_ERROR_FLAGS;
  assign wr_error_en  = reg_write_i &&
                        reg_addr_i == uif_pkg::OFS_ERROR_ENABLES;
  assign wr_address   = reg_write_i &&
                        reg_addr_i == uif_pkg::OFS_DEVICE_ADDRESS;

  ////////////////////////////////////////////////////////////////////////
  // Idle detector: counts cycles of continuous Idle, fires once per stretch
  logic [CW-1:0] idle_count;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_count <= '0;
    end else if (clock_en_i) begin
      if (!bus_idle_i) begin
        idle_count <= '0;
      end else if (idle_count != CW'(IDLE_CYCLES)) begin
        idle_count <= idle_count + CW'(1);
      end
    end
  end

  // Saturating count means one flag set per Idle stretch, not a stream
  assign idle_event = bus_idle_i &&
                      idle_count == CW'(IDLE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Event vectors
  always_comb begin
    status_events = 8'h00;
    status_events[uif_pkg::BIT_FRAME_START] = frame_start_i;
    status_events[uif_pkg::BIT_STALL_SENT]  = stall_sent_i;
    status_events[uif_pkg::BIT_BUS_IDLE]    = idle_event;
    status_events[uif_pkg::BIT_TRANS_DONE]  = transaction_done_i;
    status_events[uif_pkg::BIT_BUS_ACTIV]   = bus_activity_i;
    status_events[uif_pkg::BIT_BUS_RESET]   = bus_reset_i;
  end

  // Raw detection strobes, set the same cycle they arrive
  always_comb begin
    error_events = 8'h00;
    error_events[uif_pkg::BIT_STUFF_ERR]  = stuffing_error_i;
    error_events[uif_pkg::BIT_TURN_TMO]   = turnaround_timeout_i;
    error_events[uif_pkg::BIT_FIELD_SIZE] = field_size_error_i;
    error_events[uif_pkg::BIT_DATA_CRC]   = data_crc_error_i;
    error_events[uif_pkg::BIT_TOKEN_CRC]  = token_crc_error_i;
    error_events[uif_pkg::BIT_PID_CHECK]  = pid_check_error_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // First-level flags; bit 1 is the live error summary, bit 7 reads zero
  uif_flag_bit u_frame_start (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (status_events[uif_pkg::BIT_FRAME_START]),
    .sw_write_i  (wr_status),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_FRAME_START]),
    .sw_set_ok_i (1'b1),
    .flag_o      (usb_status_flags[uif_pkg::BIT_FRAME_START])
  );

  uif_flag_bit u_stall_sent (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (status_events[uif_pkg::BIT_STALL_SENT]),
    .sw_write_i  (wr_status),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_STALL_SENT]),
    .sw_set_ok_i (1'b1),
    .flag_o      (usb_status_flags[uif_pkg::BIT_STALL_SENT])
  );

  uif_flag_bit u_bus_idle (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (status_events[uif_pkg::BIT_BUS_IDLE]),
    .sw_write_i  (wr_status),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_BUS_IDLE]),
    .sw_set_ok_i (1'b1),
    .flag_o      (usb_status_flags[uif_pkg::BIT_BUS_IDLE])
  );

  uif_flag_bit u_trans_done (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (status_events[uif_pkg::BIT_TRANS_DONE]),
    .sw_write_i  (wr_status),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_TRANS_DONE]),
    .sw_set_ok_i (1'b1),
    .flag_o      (usb_status_flags[uif_pkg::BIT_TRANS_DONE])
  );

  uif_flag_bit u_bus_activ (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (status_events[uif_pkg::BIT_BUS_ACTIV]),
    .sw_write_i  (wr_status),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_BUS_ACTIV]),
    .sw_set_ok_i (1'b1),
    .flag_o      (usb_status_flags[uif_pkg::BIT_BUS_ACTIV])
  );

  uif_flag_bit u_bus_reset (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (status_events[uif_pkg::BIT_BUS_RESET]),
    .sw_write_i  (wr_status),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_BUS_RESET]),
    .sw_set_ok_i (1'b1),
    .flag_o      (usb_status_flags[uif_pkg::BIT_BUS_RESET])
  );
  assign usb_status_flags[uif_pkg::BIT_ERR_SUMMARY] = error_summary_flag;
  assign usb_status_flags[7] = 1'b0;

  // Second-level flags: software can only clear them, a 1 is ignored
  uif_flag_bit u_stuff_err (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (error_events[uif_pkg::BIT_STUFF_ERR]),
    .sw_write_i  (wr_error),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_STUFF_ERR]),
    .sw_set_ok_i (1'b0),
    .flag_o      (usb_error_flags[uif_pkg::BIT_STUFF_ERR])
  );

  uif_flag_bit u_turn_tmo (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (error_events[uif_pkg::BIT_TURN_TMO]),
    .sw_write_i  (wr_error),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_TURN_TMO]),
    .sw_set_ok_i (1'b0),
    .flag_o      (usb_error_flags[uif_pkg::BIT_TURN_TMO])
  );

  uif_flag_bit u_field_size (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (error_events[uif_pkg::BIT_FIELD_SIZE]),
    .sw_write_i  (wr_error),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_FIELD_SIZE]),
    .sw_set_ok_i (1'b0),
    .flag_o      (usb_error_flags[uif_pkg::BIT_FIELD_SIZE])
  );

  uif_flag_bit u_data_crc (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (error_events[uif_pkg::BIT_DATA_CRC]),
    .sw_write_i  (wr_error),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_DATA_CRC]),
    .sw_set_ok_i (1'b0),
    .flag_o      (usb_error_flags[uif_pkg::BIT_DATA_CRC])
  );

  uif_flag_bit u_token_crc (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (error_events[uif_pkg::BIT_TOKEN_CRC]),
    .sw_write_i  (wr_error),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_TOKEN_CRC]),
    .sw_set_ok_i (1'b0),
    .flag_o      (usb_error_flags[uif_pkg::BIT_TOKEN_CRC])
  );

  uif_flag_bit u_pid_check (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clock_en_i),
    .hw_set_i    (error_events[uif_pkg::BIT_PID_CHECK]),
    .sw_write_i  (wr_error),
    .sw_value_i  (reg_wdata_i[uif_pkg::BIT_PID_CHECK]),
    .sw_set_ok_i (1'b0),
    .flag_o      (usb_error_flags[uif_pkg::BIT_PID_CHECK])
  );
  assign usb_error_flags[6:5] = 2'h0;

  // Summary is a live OR, so software can neither set nor clear it
  assign error_summary_flag =
    |(usb_error_flags & usb_error_enables);

  ////////////////////////////////////////////////////////////////////////
  // Enable registers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      usb_status_enables <= uif_pkg::RESET_FLAGS;
    end else if (clock_en_i && wr_status_en) begin
      usb_status_enables <= reg_wdata_i & uif_pkg::STATUS_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      usb_error_enables <= uif_pkg::RESET_FLAGS;
    end else if (clock_en_i && wr_error_en) begin
      usb_error_enables <= reg_wdata_i & uif_pkg::ERROR_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device address; a bus reset beats a same-cycle software write
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      device_address_reg_o <= uif_pkg::RESET_ADDRESS;
    end else if (clock_en_i) begin
      if (bus_reset_i) begin
        device_address_reg_o <= uif_pkg::RESET_ADDRESS;
      end else if (wr_address) begin
        device_address_reg_o <= reg_wdata_i[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Combined request, registered so the processor sees a clean level
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      combined_usb_request_flag_o <= 1'b0;
    end else if (clock_en_i) begin
      combined_usb_request_flag_o <=
        |(usb_status_flags & usb_status_enables);
    end
  end

  always_comb begin
    peripheral_flag_reg_two_o = 8'h00;
    peripheral_flag_reg_two_o[uif_pkg::BIT_USB_REQUEST] =
      combined_usb_request_flag_o;
  end

  ////////////////////////////////////////////////////////////////////////
  // Engine-facing strobes
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      token_crc_reject_o <= 1'b0;
    end else if (clock_en_i) begin
      token_crc_reject_o <= token_crc_error_i;
    end
  end

  // Only a real 1-to-0 clear advances the FIFO, not a write to a clear bit
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_fifo_advance_o <= 1'b0;
    end else if (clock_en_i) begin
      status_fifo_advance_o <= wr_status &&
        !reg_wdata_i[uif_pkg::BIT_TRANS_DONE] &&
        usb_status_flags[uif_pkg::BIT_TRANS_DONE] &&
        !transaction_done_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clock_en_i) begin
      if (reg_read_i) begin
        case (reg_addr_i)
          uif_pkg::OFS_STATUS_FLAGS:   reg_rdata_o <= usb_status_flags;
          uif_pkg::OFS_STATUS_ENABLES: reg_rdata_o <= usb_status_enables;
          uif_pkg::OFS_ERROR_FLAGS:    reg_rdata_o <= usb_error_flags;
          uif_pkg::OFS_ERROR_ENABLES:  reg_rdata_o <= usb_error_enables;
          uif_pkg::OFS_DEVICE_ADDRESS: begin
            reg_rdata_o <= {1'b0, device_address_reg_o};
          end
          uif_pkg::OFS_PERIPH_FLAGS: begin
            reg_rdata_o <= peripheral_flag_reg_two_o;
          end
          default:                     reg_rdata_o <= 8'h00;
        endcase
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end
endmodule

// *** bench/uif_funnel_properties.sv ***
// Port-level checks of the funnel, bound into every funnel instance.
// Assumes clock_en_i is high around every checked sequence.
`timescale 1ns/100ps
module uif_funnel_properties (
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_write_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  // Engine events
  input wire logic       frame_start_i,
  input wire logic       stall_sent_i,
  input wire logic       bus_reset_i,
  input wire logic       token_crc_error_i,
  input wire logic       pid_check_error_i,
  // Outputs
  input wire logic       combined_usb_request_flag_o,
  input wire logic [7:0] peripheral_flag_reg_two_o,
  input wire logic [6:0] device_address_reg_o,
  input wire logic       token_crc_reject_o,
  input wire logic       status_fifo_advance_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence rd_at(logic [2:0] a);
    reg_read_i && reg_addr_i == a;
  endsequence
  chk_request_bit: assert property (
    peripheral_flag_reg_two_o == {2'h0, combined_usb_request_flag_o, 5'h00})
    else $error("request bit misplaced");
  chk_crc_reject: assert property (
    token_crc_error_i |=> token_crc_reject_o)
    else $error("bad token not rejected");
  chk_stall_flag: assert property (
    stall_sent_i ##1 !reg_write_i ##1 rd_at(3'h0) |=> reg_rdata_o[5])
    else $error("stall flag not set");
  chk_frame_flag: assert property (
    frame_start_i ##1 !reg_write_i ##1 rd_at(3'h0) |=> reg_rdata_o[6])
    else $error("frame flag not set");
  chk_pid_flag: assert property (
    pid_check_error_i ##1 !reg_write_i ##1 rd_at(3'h2) |=> reg_rdata_o[0])
    else $error("pid error flag late");
  chk_addr_reset: assert property (
    bus_reset_i |=> device_address_reg_o == 7'h00)
    else $error("address kept after bus reset");
  chk_fifo_cause: assert property (
    status_fifo_advance_o |-> $past(reg_write_i) &&
    $past(reg_addr_i) == 3'h0 && ($past(reg_wdata_i) & 8'h08) == 8'h00)
    else $error("advance without clear");
  chk_soft_set: assert property (
    reg_write_i && reg_addr_i == 3'h0 && reg_wdata_i[6] ##1 !reg_write_i
    ##1 rd_at(3'h0) |=> reg_rdata_o[6])
    else $error("software set lost");
  cover property (combined_usb_request_flag_o);
  cover property (status_fifo_advance_o);
  cover property (token_crc_reject_o);
endmodule

bind uif_funnel uif_funnel_properties uif_funnel_properties_inst (
  .clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
  .reg_read_i, .reg_rdata_o, .frame_start_i, .stall_sent_i, .bus_reset_i,
  .token_crc_error_i, .pid_check_error_i, .combined_usb_request_flag_o,
  .peripheral_flag_reg_two_o, .device_address_reg_o, .token_crc_reject_o,
  .status_fifo_advance_o);

// *** bench/uif_engine_model.sv ***
// Behavioural serial engine: one-cycle event pulses and an Idle level.
// Assumes one caller at a time per task.
`timescale 1ns/100ps
module uif_engine_model (
  // Clock
  input  wire logic        clock_i,
  // Events and Idle level
  output logic      [10:0] event_o,
  output logic             idle_o
);
  initial begin
    event_o = 11'h000;
    idle_o  = 1'b0;
  end
  // Pulse drops after one cycle, so the funnel must hold the flag alone
  task automatic fire(input logic [10:0] which);
    @(posedge clock_i);
    event_o <= which;
    @(posedge clock_i);
    event_o <= 11'h000;
  endtask
  task automatic idle(input int cycles);
    @(posedge clock_i);
    idle_o <= 1'b1;
    repeat (cycles) @(posedge clock_i);
    idle_o <= 1'b0;
  endtask
endmodule

// *** bench/uif_funnel_tb.sv ***
// Self-checking bench of the funnel with the engine model beside it.
// Assumes a short idle count so the idle case runs in a few cycles.
`timescale 1ns/100ps
module uif_funnel_tb;
  localparam int IDLE_N = 8;
  logic        clock_i     = 1'b0;
  logic        reset_n_i   = 1'b0;
  logic        clock_en_i  = 1'b1;
  logic [2:0]  reg_addr_i  = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i  = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic [7:0]  pflag;
  logic [6:0]  dev_addr;
  logic [10:0] ev;
  logic        req;
  logic        reject;
  logic        advance;
  logic        idle;
  logic        adv_seen;
  int          n_mismatch  = 0;
  int          compares    = 0;
  int          cycles      = 0;
  always #20 clock_i = ~clock_i;
  uif_engine_model uif_engine_model_inst (
    .clock_i(clock_i), .event_o(ev), .idle_o(idle));
  uif_funnel #(.IDLE_CYCLES(IDLE_N)) uif_funnel_inst (
    .clock_i, .reset_n_i, .clock_en_i, .reg_addr_i, .reg_wdata_i,
    .reg_write_i, .reg_read_i, .reg_rdata_o,
    .frame_start_i(ev[10]), .stall_sent_i(ev[9]), .bus_idle_i(idle),
    .transaction_done_i(ev[8]), .bus_activity_i(ev[7]),
    .bus_reset_i(ev[6]), .stuffing_error_i(ev[5]),
    .turnaround_timeout_i(ev[4]), .field_size_error_i(ev[3]),
    .data_crc_error_i(ev[2]), .token_crc_error_i(ev[1]),
    .pid_check_error_i(ev[0]), .combined_usb_request_flag_o(req),
    .peripheral_flag_reg_two_o(pflag), .device_address_reg_o(dev_addr),
    .token_crc_reject_o(reject), .status_fifo_advance_o(advance));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
    #1 adv_seen = advance;
  endtask
  task automatic rdchk(logic [2:0] a, logic [7:0] exp, string what);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1 chk(what, reg_rdata_o, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_status();
    int b [5] = '{6, 5, 3, 2, 0};
    wr(3'h4, 8'h2a);
    rdchk(3'h4, 8'h2a, "address");
    for (int i = 0; i < 5; i++) begin
      uif_engine_model_inst.fire(11'h400 >> i);
      rdchk(3'h0, 8'(1 << b[i]), "status flag");
      chk("masked request", {7'h00, req}, 8'h00);
      wr(3'h0, 8'h00);
      chk("advance", {7'h00, adv_seen}, {7'h00, b[i] == 3});
      rdchk(3'h0, 8'h00, "status cleared");
    end
    rdchk(3'h4, 8'h00, "address after bus reset");
    chk("address port", {1'b0, dev_addr}, 8'h00);
  endtask
  task automatic t_request();
    wr(3'h1, 8'h20);
    uif_engine_model_inst.fire(11'h200);
    repeat (2) @(posedge clock_i);
    #1 chk("peripheral flags", pflag, 8'h20);
    wr(3'h1, 8'h00);
    @(posedge clock_i);
    #1 chk("request off", pflag, 8'h00);
    rdchk(3'h0, 8'h20, "flag kept");
    wr(3'h0, 8'hff);
    rdchk(3'h0, 8'h7d, "software set");
    wr(3'h0, 8'h00);
  endtask
  task automatic t_errors();
    int b [6] = '{7, 4, 3, 2, 1, 0};
    for (int i = 0; i < 6; i++) begin
      uif_engine_model_inst.fire(11'h020 >> i);
      #1 chk("reject", {7'h00, reject}, {7'h00, i == 4});
      rdchk(3'h2, 8'(1 << b[i]), "error flag");
      rdchk(3'h0, 8'h00, "masked summary");
      wr(3'h2, 8'hff);
      rdchk(3'h2, 8'(1 << b[i]), "error write one");
      wr(3'h2, 8'h00);
      rdchk(3'h2, 8'h00, "error cleared");
    end
    wr(3'h3, 8'hff);
    rdchk(3'h3, 8'h9f, "error enables");
    wr(3'h1, 8'h02);
    uif_engine_model_inst.fire(11'h001);
    rdchk(3'h0, 8'h02, "summary");
    chk("summary request", {7'h00, req}, 8'h01);
    wr(3'h0, 8'h00);
    rdchk(3'h0, 8'h02, "summary write");
    wr(3'h2, 8'h00);
    rdchk(3'h0, 8'h00, "summary follows");
    wr(3'h1, 8'h00);
  endtask
  task automatic t_idle_collide();
    uif_engine_model_inst.idle(IDLE_N / 2);
    rdchk(3'h0, 8'h00, "short idle");
    uif_engine_model_inst.idle(IDLE_N + 4);
    rdchk(3'h0, 8'h10, "long idle");
    fork
      uif_engine_model_inst.fire(11'h200);
      wr(3'h0, 8'h00);
    join
    rdchk(3'h0, 8'h20, "set beats clear");
  endtask
  // A write while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge clock_i);
    clock_en_i <= 1'b0;
    wr(3'h1, 8'h7f);
    @(posedge clock_i);
    clock_en_i <= 1'b1;
    rdchk(3'h1, 8'h00, "frozen write");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rdchk(3'(a), 8'h00, "reset value");
    end
    t_status();
    t_request();
    t_errors();
    t_idle_collide();
    t_freeze();
    finish_test();
  end
endmodule
